// File: common/cie_file_if.sv
// Purpose: file register store access bundle
// Assumes: one write port, one asynchronous read port
// Notes: owner drives addresses and strobe, store returns data
`default_nettype none
interface cie_file_if;
  logic [6:0] raddr;
  logic [7:0] rdata;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic       wen;
  modport owner (output raddr, waddr, wdata, wen, input rdata);
  modport store (input raddr, waddr, wdata, wen, output rdata);
endinterface
`default_nettype wire

// File: common/cie_map.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one word per register
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH
`define CIE_OFF_ISSUE    12'h000
`define CIE_OFF_ACC      12'h004
`define CIE_OFF_STATUS   12'h008
`define CIE_OFF_PC       12'h00C
`define CIE_OFF_STACK    12'h010
`define CIE_OFF_FADDR    12'h014
`define CIE_OFF_FDATA    12'h018
`define CIE_OFF_WDT      12'h01C
`define CIE_OFF_WAKE     12'h020
`define CIE_ISS_OP_LSB   12
`define CIE_ISS_DEST_BIT 8
`define CIE_ST_C         0
`define CIE_ST_DC        1
`define CIE_ST_Z         2
`define CIE_ST_PD        3
`define CIE_ST_TO        4
`define CIE_ST_BUSY      8
`define CIE_ST_HALT      9
`define CIE_ACC_RST      8'h00
`define CIE_PC_RST       13'h0000
`define CIE_FLAG_PD_RST  1'b1
`define CIE_FLAG_TO_RST  1'b1
`define CIE_WDT_CLR      8'h00
`define CIE_RET_CYCLES   2
`define CIE_RESP_OKAY    2'h0
`define CIE_RESP_SLVERR  2'h2
`endif

// File: common/cie_pkg.sv
// Purpose: shared types of the instruction subset executor
// Assumes: nothing beyond the map header
// Notes: operation codes follow enum order, issue field is 3 bits
`default_nettype none
package cie_pkg;
  typedef enum logic [2:0] {
    OP_RETURN, OP_HALT, OP_SUBL, OP_XORL, OP_SUBF, OP_XORF, OP_NIBBLE_EXCHANGE_FILE, OP_NONE
  } cie_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2, ST_HALT} cie_state_e;
  typedef logic [12:0] cie_pc_t;
endpackage
`default_nettype wire

// File: design/cie_exec.sv
// Purpose: executes return, halt, subtract, xor and nibble exchange
// Assumes: one clock is one instruction cycle; AXI4-Lite register access
// Notes: issue register launches one instruction; wake register ends halt
`include "cie_map.svh"
`default_nettype none
module cie_exec (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             osc_stop,
  output logic             halted
);
  cie_pkg::cie_state_e state_reg;
  cie_pkg::cie_op_e    op_reg;
  cie_pkg::cie_pc_t    pc_reg;
  cie_pkg::cie_pc_t    stack_top_entry;
  logic [7:0]  arg_reg;
  logic        dest_reg;
  logic [7:0]  acc_reg;
  logic        arith_borrow_flag, half_borrow_flag, result_null_flag;
  logic        powerdown_flag, watchdog_expiry_flag;
  logic [7:0]  watchdog_counter, wdt_pre_reg;
  logic [6:0]  faddr_reg;
  logic [3:0]  stack_depth;
  logic        aw_have_reg, w_have_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg, rvalid_reg, arready_reg, osc_stop_reg, halted_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  cie_file_if fio ();

  cie_file_store u_file (
    .clock (clock),
    .fio   (fio)
  );

  logic wr_fire, wr_hit, in_exec, st_push;
  logic [31:0] wr_old, wr_val;

  cie_stack u_stack (
    .clock     (clock),
    .rstn      (rstn),
    .push      (st_push),
    .pop       (in_exec && op_reg == cie_pkg::OP_RETURN),
    .push_data (wr_val[12:0]),
    .top       (stack_top_entry),
    .depth     (stack_depth)
  );

  // read view of every register, shared by the read path and byte merges
  function automatic logic [32:0] reg_view(input logic [11:0] a);
    logic [32:0] v;
    v = 33'h0_0000_0001;
    case (a)
      `CIE_OFF_ISSUE:  v = {1'b1, 16'h0000, 1'b0, op_reg, 3'h0, dest_reg, arg_reg};
      `CIE_OFF_ACC:    v = {1'b1, 24'h00_0000, acc_reg};
      `CIE_OFF_STATUS: v = {1'b1, 22'h00_0000, halted_reg, state_reg != cie_pkg::ST_IDLE &&
                            state_reg != cie_pkg::ST_HALT, 3'h0, watchdog_expiry_flag,
                            powerdown_flag, result_null_flag, half_borrow_flag,
                            arith_borrow_flag};
      `CIE_OFF_PC:     v = {1'b1, 19'h0_0000, pc_reg};
      `CIE_OFF_STACK:  v = {1'b1, 28'h000_0000, stack_depth};
      `CIE_OFF_FADDR:  v = {1'b1, 25'h000_0000, faddr_reg};
      `CIE_OFF_FDATA:  v = {1'b1, 24'h00_0000, fio.rdata};
      `CIE_OFF_WDT:    v = {1'b1, 16'h0000, wdt_pre_reg, watchdog_counter};
      `CIE_OFF_WAKE:   v = {1'b1, 32'h0000_0000};
      default:         v = 33'h0_0000_0000;
    endcase
    return v;
  endfunction

  // write takes effect once address and data are both held
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_old  = reg_view(awaddr_reg)[31:0];
  assign wr_hit  = reg_view(awaddr_reg)[32];
  assign in_exec = state_reg == cie_pkg::ST_EXEC;
  assign st_push = wr_fire && awaddr_reg == `CIE_OFF_STACK;

  // unselected byte lanes keep the old content
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_val[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : wr_old[8*b +: 8];
  end

  function automatic logic wr_to(input logic [11:0] off);
    return wr_fire && awaddr_reg == off;
  endfunction

  // write address channel, taken independently of data
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 12'h000;
    end else if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_reg <= 1'b1;
      awaddr_reg  <= {s_axi_awaddr[11:2], 2'h0};
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge clock) begin
    if (!rstn) begin
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && !w_have_reg) begin
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // write response, slave error for an unmapped word
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `CIE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `CIE_RESP_OKAY : `CIE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read path, one address accepted per answer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `CIE_RESP_OKAY;
    end else if (arready_reg && s_axi_arvalid) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= reg_view({s_axi_araddr[11:2], 2'h0})[31:0];
      rresp_reg   <= reg_view({s_axi_araddr[11:2], 2'h0})[32] ? `CIE_RESP_OKAY :
                     `CIE_RESP_SLVERR;
    end else if (rvalid_reg) begin
      rvalid_reg <= !s_axi_rready;
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // operation datapath, combinational on latched operands
  logic [7:0] fval, res;
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic       to_acc, to_file, upd_sub, upd_z;

  always_comb begin
    fval    = fio.rdata;
    res     = 8'h00;
    diff    = 9'h000;
    hdiff   = 5'h00;
    upd_sub = 1'b0;
    upd_z   = 1'b0;
    to_acc  = 1'b0;
    to_file = 1'b0;
    case (op_reg)
      cie_pkg::OP_SUBL: begin
        diff    = {1'b0, arg_reg} - {1'b0, acc_reg};
        hdiff   = {1'b0, arg_reg[3:0]} - {1'b0, acc_reg[3:0]};
        res     = diff[7:0];
        upd_sub = 1'b1;
        to_acc  = 1'b1;
      end
      cie_pkg::OP_XORL: begin
        res    = acc_reg ^ arg_reg;
        upd_z  = 1'b1;
        to_acc = 1'b1;
      end
      cie_pkg::OP_SUBF: begin
        diff    = {1'b0, fval} - {1'b0, acc_reg};
        hdiff   = {1'b0, fval[3:0]} - {1'b0, acc_reg[3:0]};
        res     = diff[7:0];
        upd_sub = 1'b1;
      end
      cie_pkg::OP_XORF: begin
        res   = acc_reg ^ fval;
        upd_z = 1'b1;
      end
      cie_pkg::OP_NIBBLE_EXCHANGE_FILE: begin
        res = {fval[3:0], fval[7:4]};
      end
      default: begin
        res = 8'h00;
      end
    endcase
    if (op_reg == cie_pkg::OP_SUBF || op_reg == cie_pkg::OP_XORF ||
        op_reg == cie_pkg::OP_NIBBLE_EXCHANGE_FILE) begin
      to_acc  = !dest_reg;
      to_file = dest_reg;
    end
  end

  // file port: execution reads its operand, software gets the window
  assign fio.raddr = in_exec ? arg_reg[6:0] : faddr_reg;
  assign fio.wen   = (in_exec && to_file) || wr_to(`CIE_OFF_FDATA);
  assign fio.waddr = in_exec ? arg_reg[6:0] : faddr_reg;
  assign fio.wdata = in_exec ? res : wr_val[7:0];

  // sequencer; issue writes while busy or halted are dropped
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg    <= cie_pkg::ST_IDLE;
      op_reg       <= cie_pkg::OP_NONE;
      arg_reg      <= 8'h00;
      dest_reg     <= 1'b0;
      osc_stop_reg <= 1'b0;
      halted_reg   <= 1'b0;
    end else begin
      case (state_reg)
        cie_pkg::ST_IDLE: begin
          if (wr_to(`CIE_OFF_ISSUE)) begin
            op_reg    <= cie_pkg::cie_op_e'(wr_val[`CIE_ISS_OP_LSB +: 3]);
            arg_reg   <= wr_val[7:0];
            dest_reg  <= wr_val[`CIE_ISS_DEST_BIT];
            state_reg <= cie_pkg::ST_EXEC;
          end
        end
        cie_pkg::ST_EXEC: begin
          if (op_reg == cie_pkg::OP_RETURN) begin
            state_reg <= cie_pkg::ST_RET2;
          end else if (op_reg == cie_pkg::OP_HALT) begin
            state_reg    <= cie_pkg::ST_HALT;
            osc_stop_reg <= 1'b1;
            halted_reg   <= 1'b1;
          end else begin
            state_reg <= cie_pkg::ST_IDLE;
          end
        end
        cie_pkg::ST_RET2: begin
          state_reg <= cie_pkg::ST_IDLE;
        end
        cie_pkg::ST_HALT: begin
          // wake-up is a software write here, no wake sources modelled
          if (wr_to(`CIE_OFF_WAKE)) begin
            state_reg    <= cie_pkg::ST_IDLE;
            osc_stop_reg <= 1'b0;
            halted_reg   <= 1'b0;
          end
        end
        default: begin
          state_reg <= cie_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // accumulator; execution wins over a software write
  always_ff @(posedge clock) begin
    if (!rstn) begin
      acc_reg <= `CIE_ACC_RST;
    end else if (in_exec && to_acc) begin
      acc_reg <= res;
    end else if (wr_to(`CIE_OFF_ACC)) begin
      acc_reg <= wr_val[7:0];
    end
  end

  // arithmetic flags; return and halt leave them alone
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arith_borrow_flag <= 1'b0;
      half_borrow_flag  <= 1'b0;
      result_null_flag  <= 1'b0;
    end else if (in_exec && (upd_sub || upd_z)) begin
      if (upd_sub) begin
        arith_borrow_flag <= !diff[8];
        half_borrow_flag  <= !hdiff[4];
      end
      result_null_flag <= res == 8'h00;
    end else if (wr_to(`CIE_OFF_STATUS)) begin
      arith_borrow_flag <= wr_val[`CIE_ST_C];
      half_borrow_flag  <= wr_val[`CIE_ST_DC];
      result_null_flag  <= wr_val[`CIE_ST_Z];
    end
  end

  // power status flags
  always_ff @(posedge clock) begin
    if (!rstn) begin
      powerdown_flag       <= `CIE_FLAG_PD_RST;
      watchdog_expiry_flag <= `CIE_FLAG_TO_RST;
    end else if (in_exec && op_reg == cie_pkg::OP_HALT) begin
      powerdown_flag       <= 1'b0;
      watchdog_expiry_flag <= 1'b1;
    end else if (wr_to(`CIE_OFF_STATUS)) begin
      powerdown_flag       <= wr_val[`CIE_ST_PD];
      watchdog_expiry_flag <= wr_val[`CIE_ST_TO];
    end
  end

  // watchdog keeps counting in halt, it has its own oscillator
  always_ff @(posedge clock) begin
    if (!rstn) begin
      watchdog_counter <= `CIE_WDT_CLR;
      wdt_pre_reg      <= `CIE_WDT_CLR;
    end else if (in_exec && op_reg == cie_pkg::OP_HALT) begin
      watchdog_counter <= `CIE_WDT_CLR;
      wdt_pre_reg      <= `CIE_WDT_CLR;
    end else begin
      wdt_pre_reg <= wdt_pre_reg + 8'h01;
      if (wdt_pre_reg == 8'hFF) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // program counter and file window address
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pc_reg    <= `CIE_PC_RST;
      faddr_reg <= 7'h00;
    end else begin
      if (in_exec && op_reg == cie_pkg::OP_RETURN) begin
        pc_reg <= stack_top_entry;
      end else if (wr_to(`CIE_OFF_PC)) begin
        pc_reg <= wr_val[12:0];
      end
      if (wr_to(`CIE_OFF_FADDR)) begin
        faddr_reg <= wr_val[6:0];
      end
    end
  end

  assign s_axi_awready = !aw_have_reg && !bvalid_reg && rstn;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg && rstn;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign osc_stop      = osc_stop_reg;
  assign halted        = halted_reg;
endmodule
`default_nettype wire

// File: design/cie_file_store.sv
// Purpose: 128 file registers of 8 bits in flip-flops
// Assumes: synchronous write, combinational read
// Notes: contents are not reset, as in real register files
`default_nettype none
module cie_file_store (
  input wire logic clock,
  cie_file_if.store fio
);
  logic [7:0] mem_reg [128];

  // one generate loop, each entry loads on its own address
  for (genvar i = 0; i < 128; i++) begin : g_ent
    always_ff @(posedge clock) begin
      if (fio.wen && fio.waddr == 7'(i)) begin
        mem_reg[i] <= fio.wdata;
      end
    end
  end

  assign fio.rdata = mem_reg[fio.raddr];
endmodule
`default_nettype wire

// File: design/cie_stack.sv
// Purpose: eight level return stack
// Assumes: push and pop never in the same cycle
// Notes: pointer wraps on overflow, old entries are overwritten
`default_nettype none
module cie_stack (
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire logic           push,
  input  wire logic           pop,
  input  wire cie_pkg::cie_pc_t push_data,
  output cie_pkg::cie_pc_t    top,
  output logic [3:0]          depth
);
  cie_pkg::cie_pc_t ent_reg [8];
  logic [2:0]       sp_reg;
  logic [3:0]       depth_reg;

  // circular pointer, like a real hardware stack it silently wraps
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp_reg <= 3'h0;
    end else if (push) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (pop) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  // fill level saturates at eight and floors at zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      depth_reg <= 4'h0;
    end else if (push && depth_reg != 4'h8) begin
      depth_reg <= depth_reg + 4'h1;
    end else if (pop && depth_reg != 4'h0) begin
      depth_reg <= depth_reg - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      ent_reg[sp_reg] <= push_data;
    end
  end

  assign top   = ent_reg[sp_reg - 3'h1];
  assign depth = depth_reg;
endmodule
`default_nettype wire

// File: sim/cie_exec_chk.sv
// Purpose: port checks of the instruction subset executor
// Assumes: bound to cie_exec, one clock, sync active-low reset
// Notes: internal results show only through reads, checked by the bench
`default_nettype none
module cie_exec_chk (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        osc_stop,
  input wire logic        halted
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // handshake steps that start each answer, and the write answer window
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_answer;
    ##[1:3] s_axi_bvalid;
  endsequence

  a_halt_osc_tied: assert property (halted == osc_stop)
    else $error("oscillator stop and halt state differ");
  a_halt_from_write: assert property ($rose(halted) |->
    $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("halt entered without a register write");
  a_halt_leave_write: assert property ($fell(halted) |-> ##[0:2] s_axi_bvalid)
    else $error("halt left without a register write");
  a_write_answer: assert property (wr_take |-> wr_answer)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during answer");
endmodule
bind cie_exec cie_exec_chk u_chk (
  .clock, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .osc_stop, .halted
);
`default_nettype wire

// File: sim/cpu_instr_subset_exec_bench.sv
// Purpose: self-checking bench of the instruction subset executor
// Assumes: AXI4-Lite master in this module, 250 MHz clock
// Notes: file registers are written before any read, they are not reset
`include "cie_map.svh"
`default_nettype none
module cpu_instr_subset_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rstn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        osc_stop;
  logic        halted;
  int          errors;
  int          samples_checked;
  int          cycles;

  cie_exec DUT (
    .clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_stop, .halted
  );

  // free running clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // hang guard, far above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    while (aw_p || w_p) begin
      @(posedge clock);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_word(d, e);
  endtask

  task automatic iss(input logic [2:0] op, input logic dst, input logic [7:0] k);
    w(`CIE_OFF_ISSUE, {17'h0, op, 3'h0, dst, k});
  endtask

  // expected status after a subtract, expiry and powerdown left at one
  function automatic logic [31:0] sub_st(input logic [7:0] k, input logic [7:0] a);
    logic [7:0] q;
    q = k - a;
    return {27'h0, 2'b11, q == 8'h00, k[3:0] >= a[3:0], k >= a};
  endfunction

  task automatic t_reset;
    rchk(`CIE_OFF_STATUS, 32'h0000_0018);
    rchk(`CIE_OFF_ACC, 32'h0000_0000);
    $display("test reset done");
  endtask

  // borrow and half borrow on both sides, zero result
  task automatic t_sub_lit;
    logic [7:0] ak [4] = '{8'h05, 8'h13, 8'h0F, 8'h01};
    logic [7:0] kk [4] = '{8'h03, 8'h13, 8'h10, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      w(`CIE_OFF_ACC, {24'h0, ak[i]});
      iss(cie_pkg::OP_SUBL, 1'b0, kk[i]);
      rchk(`CIE_OFF_ACC, {24'h0, 8'(kk[i] - ak[i])});
      rchk(`CIE_OFF_STATUS, sub_st(kk[i], ak[i]));
    end
    $display("test sub_literal done");
  endtask

  task automatic t_xor_lit;
    w(`CIE_OFF_STATUS, 32'h0000_001B);
    w(`CIE_OFF_ACC, 32'h0000_00A5);
    iss(cie_pkg::OP_XORL, 1'b0, 8'hA5);
    rchk(`CIE_OFF_ACC, 32'h0000_0000);
    rchk(`CIE_OFF_STATUS, 32'h0000_001F);
    iss(cie_pkg::OP_XORL, 1'b0, 8'h0F);
    rchk(`CIE_OFF_ACC, 32'h0000_000F);
    rchk(`CIE_OFF_STATUS, 32'h0000_001B);
    $display("test xor_literal done");
  endtask

  // subtract, xor and swap on both ends of the file space, both targets
  task automatic t_file_ops;
    logic [7:0]  res;
    logic [31:0] st;
    logic [6:0]  fa;
    for (int o = 4; o < 7; o++) begin
      for (int d = 0; d < 2; d++) begin
        fa = d ? 7'h7F : 7'h00;
        w(`CIE_OFF_STATUS, 32'h0000_001C);
        w(`CIE_OFF_FADDR, {25'h0, fa});
        w(`CIE_OFF_FDATA, 32'h0000_003C);
        w(`CIE_OFF_ACC, 32'h0000_002A);
        iss(3'(o), d[0], {1'b0, fa});
        res = o == 4 ? 8'h12 : o == 5 ? 8'h16 : 8'hC3;
        st = o == 4 ? sub_st(8'h3C, 8'h2A) : o == 5 ? 32'h0000_0018 : 32'h0000_001C;
        rchk(`CIE_OFF_ACC, {24'h0, d ? 8'h2A : res});
        rchk(`CIE_OFF_FDATA, {24'h0, d ? res : 8'h3C});
        rchk(`CIE_OFF_STATUS, st);
      end
    end
    $display("test file_ops done");
  endtask

  task automatic t_return;
    w(`CIE_OFF_STATUS, 32'h0000_001F);
    w(`CIE_OFF_STACK, 32'h0000_1ABC);
    w(`CIE_OFF_STACK, 32'h0000_0123);
    rchk(`CIE_OFF_STACK, 32'h0000_0002);
    iss(cie_pkg::OP_RETURN, 1'b0, 8'h00);
    rchk(`CIE_OFF_PC, 32'h0000_0123);
    rchk(`CIE_OFF_STACK, 32'h0000_0001);
    rchk(`CIE_OFF_STATUS, 32'h0000_001F);
    iss(cie_pkg::OP_RETURN, 1'b0, 8'h00);
    rchk(`CIE_OFF_PC, 32'h0000_1ABC);
    $display("test return done");
  endtask

  // watchdog first runs long enough that its counter has stepped
  task automatic t_halt;
    logic [31:0] d;
    logic [31:0] acc;
    logic [1:0]  r;
    w(`CIE_OFF_STATUS, 32'h0000_001B);
    repeat (600) @(posedge clock);
    iss(cie_pkg::OP_HALT, 1'b0, 8'h00);
    repeat (3) @(posedge clock);
    chk_flag(halted, 1'b1);
    chk_flag(osc_stop, 1'b1);
    rchk(`CIE_OFF_STATUS, 32'h0000_0213);
    rd(`CIE_OFF_WDT, d, r);
    chk_word({24'h0, d[7:0]}, 32'h0000_0000);
    chk_flag(d[15:8] < 8'h20, 1'b1);
    rd(`CIE_OFF_ACC, acc, r);
    iss(cie_pkg::OP_XORL, 1'b0, 8'hFF);
    rchk(`CIE_OFF_ACC, acc);
    w(`CIE_OFF_WAKE, 32'h0000_0000);
    repeat (2) @(posedge clock);
    chk_flag(halted, 1'b0);
    chk_flag(osc_stop, 1'b0);
    $display("test halt done");
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    wr(12'h100, 32'h0000_0055, r);
    chk_word({30'h0, r}, {30'h0, `CIE_RESP_SLVERR});
    rd(12'h100, d, r);
    chk_word(d, 32'h0000_0000);
    chk_word({30'h0, r}, {30'h0, `CIE_RESP_SLVERR});
    $display("test unmapped done");
  endtask

  // main sequence, reset held three cycles
  initial begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    rstn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_sub_lit();
    t_xor_lit();
    t_file_ops();
    t_return();
    t_halt();
    t_unmapped();
    results();
  end
endmodule
`default_nettype wire
